// ---- cwd_config_decode.sv ----
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module cwd_config_decode (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power supervisor and pins (asynchronous, synchronised here)
    input wire logic power_brown_reset_n,
    input wire logic master_clear_pin_n,
    input wire logic prog_mode,
    input wire logic osc_locked_in,
    input wire logic osc_stable_in,
    // Programmer port for configuration words
    input wire logic prog_wr,
    input wire logic prog_rd,
    input wire logic [15:0] prog_addr,
    input wire logic [13:0] prog_wdata,
    output logic [13:0] prog_rdata,
    output logic prog_erase_all,
    output logic mem_read_block,
    // Decoded options
    output logic [2:0] osc_mode,
    output logic osc_pin_two_clock_en,
    output logic divided_clock_output,
    output logic osc_pin_one_is_io,
    output logic osc_pin_two_is_io,
    output logic debug_pins_dedicated,
    output logic fast_base_select,
    output logic [1:0] internal_freq_select,
    output logic [5:0] freq_trim,
    output logic brownout_reset_en,
    output logic brownout_sleep_off,
    output logic brownout_level_select,
    output logic powerup_timer_en,
    output logic watchdog_en,
    output logic reset_pin_is_reset,
    output logic core_reset_n,
    output logic int_osc_stop
);
    import cwd_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sync_master_clear_n, sync_pbr, sync_prog, sync_lock, sync_stab;
    logic master_clear_n_n_s, pbr_n_s, prog_s, lock_s, stab_s;

    // Two flops per pin input; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_master_clear_n <= 2'h3;
            sync_pbr <= 2'h0;
            sync_prog <= 2'h0;
            sync_lock <= 2'h0;
            sync_stab <= 2'h0;
        end else begin
            sync_master_clear_n <= {sync_master_clear_n[0], master_clear_pin_n};
            sync_pbr <= {sync_pbr[0], power_brown_reset_n};
            sync_prog <= {sync_prog[0], prog_mode};
            sync_lock <= {sync_lock[0], osc_locked_in};
            sync_stab <= {sync_stab[0], osc_stable_in};
        end
    end
    assign master_clear_n_n_s = sync_master_clear_n[1];
    assign pbr_n_s = sync_pbr[1];
    assign prog_s = sync_prog[1];
    assign lock_s = sync_lock[1];
    assign stab_s = sync_stab[1];

    // ------------------------------------------------------------------
    // Nonvolatile configuration words and programmer access
    // ------------------------------------------------------------------
    logic [13:0] word_one, word_two;
    logic prog_wr_one, prog_wr_two, cp_release;

    // Only a programmer in programming mode may reach them
    assign prog_wr_one = prog_s && prog_wr
        && (prog_addr == CWD_ADDR_WORD_ONE);
    assign prog_wr_two = prog_s && prog_wr
        && (prog_addr == CWD_ADDR_WORD_TWO);
    // Protection going from on (0) to off (1) wipes program memory
    assign cp_release = prog_wr_one
        && !word_one[CWD_BIT_CODE_PROTECT]
        && prog_wdata[CWD_BIT_CODE_PROTECT];

    // Stored words; presetn stands in for a blank part being erased
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_one <= CWD_WORD_ERASED;
            word_two <= CWD_WORD_ERASED;
        end else begin
            if (prog_wr_one)
                word_one <= prog_wdata;
            if (prog_wr_two)
                word_two <= prog_wdata;
        end
    end

    // Programmer readback and erase pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_rdata <= 14'h0000;
            prog_erase_all <= 1'b0;
        end else begin
            prog_erase_all <= cp_release;
            if (prog_s && prog_rd && prog_addr == CWD_ADDR_WORD_ONE)
                prog_rdata <= word_one;
            else if (prog_s && prog_rd && prog_addr == CWD_ADDR_WORD_TWO)
                prog_rdata <= word_two;
            else
                prog_rdata <= 14'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Option latch: word one copied while the core is held in reset
    // ------------------------------------------------------------------
    logic [13:0] opt;
    logic hold;

    // Core held by power/brown-out reset, programming mode or reset pin
    assign hold = !pbr_n_s || prog_s
        || (opt[CWD_BIT_RESET_PIN] && !master_clear_n_n_s);

    // Tracks the word while held, frozen once running, so options
    // never shift under running code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            opt <= CWD_WORD_ERASED;
        else if (hold)
            opt <= word_one;
    end

    // ------------------------------------------------------------------
    // Decoded option outputs
    // ------------------------------------------------------------------
    cwd_osc_t mode;
    logic int_or_rc;
    assign mode = cwd_osc_t'(opt[CWD_BIT_OSC_HI:0]);
    assign int_or_rc = (mode == CWD_OSC_INT_CLK) || (mode == CWD_OSC_INT_IO)
        || (mode == CWD_OSC_RC_CLK) || (mode == CWD_OSC_RC_IO);

    // Pin ownership per oscillator code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_mode <= 3'h7;
            osc_pin_two_clock_en <= 1'b1;
            osc_pin_one_is_io <= 1'b0;
            osc_pin_two_is_io <= 1'b0;
        end else begin
            osc_mode <= opt[CWD_BIT_OSC_HI:0];
            case (mode)
                CWD_OSC_RC_CLK: begin
                    osc_pin_two_clock_en <= 1'b1;
                    osc_pin_one_is_io <= 1'b0;
                    osc_pin_two_is_io <= 1'b0;
                end
                CWD_OSC_RC_IO: begin
                    osc_pin_two_clock_en <= 1'b0;
                    osc_pin_one_is_io <= 1'b0;
                    osc_pin_two_is_io <= 1'b1;
                end
                CWD_OSC_INT_CLK: begin
                    osc_pin_two_clock_en <= 1'b1;
                    osc_pin_one_is_io <= 1'b1;
                    osc_pin_two_is_io <= 1'b0;
                end
                CWD_OSC_INT_IO: begin
                    osc_pin_two_clock_en <= 1'b0;
                    osc_pin_one_is_io <= 1'b1;
                    osc_pin_two_is_io <= 1'b1;
                end
                CWD_OSC_EXT: begin
                    osc_pin_two_clock_en <= 1'b0;
                    osc_pin_one_is_io <= 1'b0;
                    osc_pin_two_is_io <= 1'b1;
                end
                default: begin
                    // Crystal modes use both pins
                    osc_pin_two_clock_en <= 1'b0;
                    osc_pin_one_is_io <= 1'b0;
                    osc_pin_two_is_io <= 1'b0;
                end
            endcase
        end
    end

    // Divide-by-4 clock output: toggles every second system clock
    logic [0:0] div_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 1'h0;
            divided_clock_output <= 1'b0;
        end else if (osc_pin_two_clock_en) begin
            div_cnt <= div_cnt + 1'h1;
            if (div_cnt == CWD_DIV_HALF_LAST)
                divided_clock_output <= !divided_clock_output;
        end else begin
            div_cnt <= 1'h0;
            divided_clock_output <= 1'b0;
        end
    end

    // Device option enables; each follows its own bit, brown-out sleep off both brown-out bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            debug_pins_dedicated <= 1'b0;
            fast_base_select <= 1'b1;
            brownout_reset_en <= 1'b1;
            brownout_sleep_off <= 1'b0;
            brownout_level_select <= 1'b1;
            powerup_timer_en <= 1'b0;
            watchdog_en <= 1'b1;
            reset_pin_is_reset <= 1'b1;
            mem_read_block <= 1'b0;
        end else begin
            // Low bit dedicates pins to the debugger
            debug_pins_dedicated <= !opt[CWD_BIT_DEBUG];
            fast_base_select <= opt[CWD_BIT_FAST_BASE];
            brownout_reset_en <= opt[CWD_BIT_BOR_HI];
            // Code 10 runs only while awake
            brownout_sleep_off <= opt[CWD_BIT_BOR_HI]
                && !opt[CWD_BIT_BOR_LO];
            brownout_level_select <= opt[CWD_BIT_BOR_LEVEL];
            // Power-up timer ignores brown-out setting
            powerup_timer_en <= !opt[CWD_BIT_POWERUP_TIMER_N];
            watchdog_en <= opt[CWD_BIT_WDT];
            reset_pin_is_reset <= opt[CWD_BIT_RESET_PIN];
            // Protection is active low; uses live word so a programmer
            // cannot read memory right after setting it
            mem_read_block <= !word_one[CWD_BIT_CODE_PROTECT];
        end
    end

    // Reset pin effect and oscillator stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n <= 1'b0;
            int_osc_stop <= 1'b0;
        end else begin
            // As digital input the internal reset stays inactive
            core_reset_n <= pbr_n_s
                && !(opt[CWD_BIT_RESET_PIN] && !master_clear_n_n_s);
            int_osc_stop <= opt[CWD_BIT_RESET_PIN] && !master_clear_n_n_s
                && int_or_rc;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator control and tuning registers
    // ------------------------------------------------------------------
    logic wr_en, rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Frequency select reloads on every reset source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            internal_freq_select <= CWD_FREQ_RESET;
        else if (hold)
            internal_freq_select <= CWD_FREQ_RESET;
        else if (wr_en && paddr == CWD_REG_OSC_CONTROL)
            internal_freq_select <= pwdata[CWD_FREQ_LO +: 2];
    end

    // Trim clears only on power-on/brown-out, survives pin reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            freq_trim <= CWD_TRIM_RESET;
        else if (!pbr_n_s)
            freq_trim <= CWD_TRIM_RESET;
        else if (wr_en && paddr == CWD_REG_OSC_TUNING)
            freq_trim <= pwdata[5:0];
    end

    // ------------------------------------------------------------------
    // APB read path: zero-wait, data registered in setup cycle
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;
    logic next_err;
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            CWD_REG_OSC_CONTROL: begin
                next_rdata[CWD_FREQ_LO +: 2] = internal_freq_select;
                next_rdata[3] = lock_s; // Locked status
                next_rdata[2] = stab_s; // Stable status
            end
            CWD_REG_OSC_TUNING:
                next_rdata[5:0] = freq_trim;
            CWD_REG_STATUS:
                next_rdata[2:0] = {prog_s, master_clear_n_n_s, pbr_n_s};
            // Words hidden from software outside programming mode
            CWD_REG_WORD_ONE:
                next_rdata[13:0] = prog_s ? word_one : 14'h0000;
            CWD_REG_WORD_TWO:
                next_rdata[13:0] = prog_s ? word_two : 14'h0000;
            default:
                next_err = 1'b1;
        endcase
    end

    // Ready for one cycle in every access phase; error flagged during access on unmapped address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            if (rd_en)
                prdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// ---- cwd_pkg.sv ----
package cwd_pkg;

// ----------------------------------------------------------------------
// Configuration word locations and layout
// ----------------------------------------------------------------------
localparam logic [15:0] CWD_ADDR_WORD_ONE = 16'h2007;
localparam logic [15:0] CWD_ADDR_WORD_TWO = 16'h2008;
localparam int CWD_WORD_W = 14;
localparam logic [13:0] CWD_WORD_ERASED = 14'h3fff;
localparam int CWD_BIT_DEBUG = 13;
localparam int CWD_BIT_FAST_BASE = 12;
localparam int CWD_BIT_BOR_LEVEL = 10;
localparam int CWD_BIT_BOR_HI = 9;
localparam int CWD_BIT_BOR_LO = 8;
localparam int CWD_BIT_CODE_PROTECT = 6;
localparam int CWD_BIT_RESET_PIN = 5;
localparam int CWD_BIT_POWERUP_TIMER_N = 4;
localparam int CWD_BIT_WDT = 3;
localparam int CWD_BIT_OSC_HI = 2;

// ----------------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------------
localparam logic [11:0] CWD_REG_OSC_CONTROL = 12'h000;
localparam logic [11:0] CWD_REG_OSC_TUNING = 12'h004;
localparam logic [11:0] CWD_REG_STATUS = 12'h008;
localparam logic [11:0] CWD_REG_WORD_ONE = 12'h00c;
localparam logic [11:0] CWD_REG_WORD_TWO = 12'h010;

// Oscillator control: frequency select at bits 5:4
localparam int CWD_FREQ_LO = 4;
localparam logic [1:0] CWD_FREQ_RESET = 2'h2;
localparam logic [5:0] CWD_TRIM_RESET = 6'h00;

// Clock output divide ratio: toggle every 2 cycles gives divide by 4
localparam logic [0:0] CWD_DIV_HALF_LAST = 1'h1;

// Oscillator selection codes
typedef enum logic [2:0] {
    CWD_OSC_LP = 3'h0,
    CWD_OSC_XT = 3'h1,
    CWD_OSC_HS = 3'h2,
    CWD_OSC_EXT = 3'h3,
    CWD_OSC_INT_IO = 3'h4,
    CWD_OSC_INT_CLK = 3'h5,
    CWD_OSC_RC_IO = 3'h6,
    CWD_OSC_RC_CLK = 3'h7
} cwd_osc_t;

endpackage

// ---- cwd_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port-level checks for the option decoder
// ----------------------------------------
module cwd_chk (
    // Bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Supply and programmer
    input wire logic prog_mode,
    input wire logic power_brown_reset_n,
    input wire logic prog_erase_all,
    // Decoded options
    input wire logic [2:0] osc_mode,
    input wire logic osc_pin_two_clock_en,
    input wire logic divided_clock_output,
    input wire logic osc_pin_two_is_io,
    input wire logic [1:0] internal_freq_select,
    input wire logic [5:0] freq_trim,
    input wire logic reset_pin_is_reset,
    input wire logic int_osc_stop
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    // Five word offsets answer without error
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    chk_ready_access: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    chk_ready_one: assert property (pready |=> !pready)
        else $error("ready stood too long");
    chk_err_unmapped: assert property (pready && !mapped |->
        pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    // Mode input passes two sync stages, so look three edges back
    chk_word_hidden: assert property (
        pready && !pwrite && paddr >= 12'h00c
        && !prog_mode && !$past(prog_mode) && !$past(prog_mode, 2)
        && !$past(prog_mode, 3) |-> prdata == 32'h0000_0000)
        else $error("word readable outside programming");
    // A mode change may cut the output short, so the enable must stand
    chk_clk_div: assert property ($rose(divided_clock_output)
        && osc_pin_two_clock_en |->
        ##1 divided_clock_output ##1 !divided_clock_output)
        else $error("clock output not divided by four");
    chk_pin_clock: assert property (osc_pin_two_clock_en ==
        (osc_mode == 3'h7 || osc_mode == 3'h5))
        else $error("second pin clock enable wrong");
    chk_pin_io: assert property (osc_pin_two_is_io ==
        (osc_mode inside {3'h6, 3'h4, 3'h3}))
        else $error("second pin io select wrong");
    chk_osc_stop: assert property (int_osc_stop |->
        reset_pin_is_reset && osc_mode[2])
        else $error("oscillator stopped in wrong mode");
    chk_erase_pulse: assert property (
        prog_erase_all |=> !prog_erase_all)
        else $error("erase pulse too long");
    chk_freq_load: assert property ($rose(presetn) |->
        internal_freq_select == 2'h2 && freq_trim == 6'h00)
        else $error("oscillator fields wrong after reset");
    chk_trim_clear: assert property ($fell(power_brown_reset_n) |->
        ##[1:6] freq_trim == 6'h00)
        else $error("trim not cleared by supply reset");
endmodule
bind cwd_config_decode cwd_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_mode(prog_mode),
    .power_brown_reset_n(power_brown_reset_n),
    .prog_erase_all(prog_erase_all), .osc_mode(osc_mode),
    .osc_pin_two_clock_en(osc_pin_two_clock_en),
    .divided_clock_output(divided_clock_output),
    .osc_pin_two_is_io(osc_pin_two_is_io),
    .internal_freq_select(internal_freq_select),
    .freq_trim(freq_trim), .reset_pin_is_reset(reset_pin_is_reset),
    .int_osc_stop(int_osc_stop)
);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cwd_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, prog_wr = 1'b0, prog_rd = 1'b0, prog_mode = 1'b0;
    logic power_brown_reset_n = 1'b1, master_clear_pin_n = 1'b1;
    logic osc_locked_in = 1'b0, osc_stable_in = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [15:0] prog_addr = 16'h0000;
    logic [13:0] prog_wdata = 14'h0000, prog_rdata;
    logic pready, pslverr, prog_erase_all, mem_read_block;
    logic osc_pin_two_clock_en, divided_clock_output, osc_pin_one_is_io;
    logic osc_pin_two_is_io, debug_pins_dedicated, fast_base_select;
    logic brownout_reset_en, brownout_sleep_off, brownout_level_select;
    logic powerup_timer_en, watchdog_en, reset_pin_is_reset, core_reset_n;
    logic int_osc_stop;
    logic [2:0] osc_mode;
    logic [1:0] internal_freq_select;
    logic [5:0] freq_trim;
    int failures = 0, samples_checked = 0, erase_seen = 0;
    logic [31:0] q;
    logic e;
    // Option words and their expected decode, one row per case
    localparam logic [13:0] OPT_W [3] = '{14'h3fff, 14'h08c7, 14'h3eff};
    localparam logic [7:0] OPT_X [3] = '{8'h67, 8'h88, 8'h77};
    // Option enables gathered in one word, level select last
    logic [7:0] opts;
    assign opts = {debug_pins_dedicated, fast_base_select, brownout_reset_en,
        brownout_sleep_off, powerup_timer_en, watchdog_en,
        reset_pin_is_reset, brownout_level_select};

    cwd_config_decode uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .power_brown_reset_n(power_brown_reset_n),
        .master_clear_pin_n(master_clear_pin_n), .prog_mode(prog_mode),
        .osc_locked_in(osc_locked_in), .osc_stable_in(osc_stable_in),
        .prog_wr(prog_wr), .prog_rd(prog_rd), .prog_addr(prog_addr),
        .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
        .prog_erase_all(prog_erase_all), .mem_read_block(mem_read_block),
        .osc_mode(osc_mode), .osc_pin_two_clock_en(osc_pin_two_clock_en),
        .divided_clock_output(divided_clock_output),
        .osc_pin_one_is_io(osc_pin_one_is_io),
        .osc_pin_two_is_io(osc_pin_two_is_io),
        .debug_pins_dedicated(debug_pins_dedicated),
        .fast_base_select(fast_base_select),
        .internal_freq_select(internal_freq_select), .freq_trim(freq_trim),
        .brownout_reset_en(brownout_reset_en),
        .brownout_sleep_off(brownout_sleep_off),
        .brownout_level_select(brownout_level_select),
        .powerup_timer_en(powerup_timer_en), .watchdog_en(watchdog_en),
        .reset_pin_is_reset(reset_pin_is_reset),
        .core_reset_n(core_reset_n), .int_osc_stop(int_osc_stop)
    );

    // Clock, and a count of one-cycle erase pulses
    always #50 pclk = ~pclk;
    always @(posedge pclk) if (prog_erase_all === 1'b1) erase_seen++;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Holds the request until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Programmer write; decode lands after sync and latch stages
    task automatic pwr(input logic [15:0] a, input logic [13:0] d);
        @(posedge pclk);
        prog_wr <= 1'b1;
        prog_addr <= a;
        prog_wdata <= d;
        @(posedge pclk);
        prog_wr <= 1'b0;
        tick(5);
    endtask
    // Programmer read; data stands one cycle after the strobe
    task automatic prd(input logic [15:0] a);
        @(posedge pclk);
        prog_rd <= 1'b1;
        prog_addr <= a;
        @(posedge pclk);
        prog_rd <= 1'b0;
        @(posedge pclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        tick(4);
        chk(osc_mode, 3'h7);
        chk(core_reset_n, 1'b1);
        apb(1'b0, CWD_REG_OSC_CONTROL, 32'h0);
        chk(q, 32'h0000_0020);
        apb(1'b0, CWD_REG_WORD_ONE, 32'h0);
        chk(q, 32'h0000_0000);
        apb(1'b0, 12'h020, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0000_0000);
        apb(1'b1, CWD_REG_OSC_TUNING, 32'h0000_0015);
        apb(1'b0, CWD_REG_OSC_TUNING, 32'h0);
        chk(q, 32'h0000_0015);
    endtask
    task automatic t_modes();
        prog_mode <= 1'b1;
        tick(4);
        for (int m = 0; m < 8; m++) begin
            pwr(CWD_ADDR_WORD_ONE, 14'h3ff8 | 14'(m));
            chk(osc_mode, m);
            chk(osc_pin_two_clock_en, m == 7 || m == 5);
            chk(osc_pin_two_is_io, m inside {6, 4, 3});
            chk(osc_pin_one_is_io, m inside {4, 5});
        end
        apb(1'b0, CWD_REG_WORD_ONE, 32'h0);
        chk(q, 32'h0000_3fff);
        pwr(CWD_ADDR_WORD_TWO, 14'h3fcf);
        apb(1'b0, CWD_REG_WORD_TWO, 32'h0);
        chk(q, 32'h0000_3fcf);
        prd(CWD_ADDR_WORD_TWO);
        chk(prog_rdata, 32'h0000_3fcf);
    endtask
    task automatic t_opts();
        for (int i = 0; i < 3; i++) begin
            pwr(CWD_ADDR_WORD_ONE, OPT_W[i]);
            chk(opts, OPT_X[i]);
        end
    endtask
    task automatic t_protect();
        pwr(CWD_ADDR_WORD_ONE, 14'h3fbf);
        chk(mem_read_block, 1'b1);
        chk(erase_seen, 0);
        pwr(CWD_ADDR_WORD_ONE, 14'h3fff);
        chk(erase_seen, 1);
        chk(mem_read_block, 1'b0);
    endtask
    task automatic t_freeze();
        prog_mode <= 1'b0;
        osc_locked_in <= 1'b1;
        tick(4);
        prd(CWD_ADDR_WORD_ONE);
        chk(prog_rdata, 32'h0000_0000);
        pwr(CWD_ADDR_WORD_ONE, 14'h3ff8);
        chk(osc_mode, 3'h7);
        apb(1'b1, CWD_REG_OSC_CONTROL, 32'h0000_0010);
        apb(1'b0, CWD_REG_OSC_CONTROL, 32'h0);
        chk(q, 32'h0000_0018);
        osc_stable_in <= 1'b1;
        master_clear_pin_n <= 1'b0;
        tick(5);
        chk({int_osc_stop, core_reset_n}, 2'b10);
        master_clear_pin_n <= 1'b1;
        tick(5);
        chk({int_osc_stop, core_reset_n}, 2'b01);
        apb(1'b0, CWD_REG_OSC_CONTROL, 32'h0);
        chk(q, 32'h0000_002c);
        chk(freq_trim, 6'h15);
        power_brown_reset_n <= 1'b0;
        tick(8);
        chk(freq_trim, 6'h00);
        power_brown_reset_n <= 1'b1;
        tick(5);
        apb(1'b0, CWD_REG_OSC_TUNING, 32'h0);
        chk(q, 32'h0000_0000);
    endtask

    // ----------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Whole run is well under a thousand cycles
    initial begin
        #2_000_000;
        failures++;
        $display("[ERR] %0t run did not finish", $time);
        give_verdict();
    end
    initial begin
        tick(12);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_opts();
        t_protect();
        t_freeze();
        give_verdict();
    end
endmodule
`default_nettype wire
